/* File: verilog/fbcis_pkg.sv */
// shared constants and types for the 4-bit core execution unit
package fbcis_pkg;
  localparam int PC_W = 14;
  localparam int PAGE_W = 7;
  localparam int STACK_DEPTH = 8;
  localparam int SP_W = 3;
  localparam int DP_W = 10;
  localparam int NIB_W = 4;
  localparam int WORD_W = 10;
  localparam int ADC_W = 10;
  localparam int NREQ = 9;
  localparam int NRELOAD = 7;
  localparam int RELOAD_W = 8;
  localparam int LCD_RELOAD_W = 4;
  // reset values
  localparam logic [PC_W-1:0] PC_RESET = 14'h0000;
  localparam logic [SP_W-1:0] SP_RESET = 3'h0;
  localparam logic [NIB_W-1:0] NIB_RESET = 4'h0;
  localparam logic [RELOAD_W-1:0] RELOAD_RESET = 8'h00;
  localparam logic BIT_RESET = 1'b0;
  // page that the short call always lands in
  localparam logic [PAGE_W-1:0] CALL_PAGE = 7'h02;
  // instruction group, word bits 9:7
  localparam logic [2:0] G_MISC = 3'h0;
  localparam logic [2:0] G_RELOAD = 3'h2;
  localparam logic [2:0] G_TABLE_READ_PAGED = 3'h3;
  localparam logic [2:0] G_IMM = 3'h4;
  localparam logic [2:0] G_BL = 3'h5;
  localparam logic [2:0] G_CALL = 3'h6;
  localparam logic [2:0] G_BR = 3'h7;
  // immediate sub-operation, word bits 6:4
  localparam logic [2:0] I_LA = 3'h0;
  localparam logic [2:0] I_ADD = 3'h1;
  localparam logic [2:0] I_SEA = 3'h2;
  localparam logic [2:0] I_LX = 3'h3;
  localparam logic [2:0] I_LY = 3'h4;
  localparam logic [2:0] I_LZ = 3'h5;
  // misc operation codes, word bits 6:0
  localparam logic [6:0] M_NOP = 7'h00;
  localparam logic [6:0] M_AM = 7'h01;
  localparam logic [6:0] M_AMC = 7'h02;
  localparam logic [6:0] M_TAM = 7'h03;
  localparam logic [6:0] M_TMA = 7'h04;
  localparam logic [6:0] M_SC = 7'h05;
  localparam logic [6:0] M_RC = 7'h06;
  localparam logic [6:0] M_DI = 7'h07;
  localparam logic [6:0] M_EI = 7'h08;
  localparam logic [6:0] M_READ_CONVERTER_RESULT = 7'h09;
  localparam logic [6:0] M_READ_CONVERTER_LOW_BITS = 7'h0A;
  localparam logic [6:0] M_CONVERTER_START = 7'h0B;
  localparam logic [6:0] M_TAI3 = 7'h0C;
  localparam logic [6:0] M_TI3A = 7'h0D;
  localparam logic [6:0] M_RT = 7'h0E;
  localparam logic [6:0] M_RTS = 7'h0F;
  localparam logic [6:0] M_RTI = 7'h11;
  localparam logic [6:0] M_LVL0 = 7'h12;
  localparam logic [6:0] M_LVL1 = 7'h13;
  // skip on request k uses code M_SKREQ + k
  localparam logic [6:0] M_SKREQ = 7'h20;
  // request flag positions
  localparam int R_EXT0 = 0;
  localparam int R_EXT1 = 1;
  localparam int R_T1 = 2;
  localparam int R_CONV = 7;
  localparam int R_SER = 8;
  // reload bank positions
  localparam int RL_PS = 0;
  localparam int RL_T1 = 1;
  localparam int RL_T2 = 2;
  localparam int RL_T3 = 3;
  localparam int RL_T4L = 4;
  localparam int RL_T4H = 5;
  localparam int RL_LCD = 6;
  typedef enum logic [4:0] {
    ST_EXEC = 5'b00001,
    ST_BL2 = 5'b00010,
    ST_TAB2 = 5'b00100,
    ST_TAB3 = 5'b01000,
    ST_RET2 = 5'b10000
  } fbcis_state_t;
endpackage

/* File: verilog/fbcis_flag.sv */
`timescale 1ns/1ps
// sticky request flag set by a peripheral event, cleared by a skip test
module fbcis_flag (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic set_in,
  input wire logic clear_in,
  output logic flag_out
);
  // set outranks clear so an event in the clearing cycle survives
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      flag_out <= fbcis_pkg::BIT_RESET;
    end else if (set_in) begin
      flag_out <= 1'b1;
    end else if (clear_in) begin
      flag_out <= 1'b0;
    end
  end
endmodule

/* File: verilog/fbcis_core.sv */
`timescale 1ns/1ps
// 4-bit core: sequencing, skip, stack, pointer, flag tests, reloads
// Overview of operation
// - after a met skip the next instruction is fetched but has no effect
// - a skip never adds an extra step to the program counter
// - a suppressed long branch keeps its normal two-cycle count
// - suppressed table read or plain returns take exactly one cycle
// - 14-bit counter, 7-bit page and 7-bit in-page halves loaded apart
// - eight 14-bit stack entries, 3-bit index, pre-increment push
// - 10-bit memory pointer from file and two index nibbles
// - add with carry sums accumulator, memory, carry; carry-out saved
// - external request tests skip and clear only with enable low
// - pin level tests skip on high or low per polarity bit
// - timer request tests skip and clear only with enable low
// - conversion-done test skips and clears only with enable low
// - serial-done test skips and clears only with enable low
// - result read gives bits 9:6,5:2 or 7:4,3:0 by mode
// - 8-bit reloads for prescaler, timers 1-4 pair, 4-bit lcd
// - third interrupt control is one bit via acc bit 0
// - converter start clears done flag and starts by mode bit
// - adds without carry leave the carry flag alone
module fbcis_core (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic [fbcis_pkg::PC_W-1:0] pmem_addr_out,
  input wire logic [fbcis_pkg::WORD_W-1:0] instr_in,
  output logic [fbcis_pkg::DP_W-1:0] dmem_addr_out,
  input wire logic [fbcis_pkg::NIB_W-1:0] dmem_rdata_in,
  output logic [fbcis_pkg::NIB_W-1:0] dmem_wdata_out,
  output logic dmem_we_out,
  input wire logic ext0_pin_in,
  input wire logic ext1_pin_in,
  input wire logic ext0_polarity_bit_in,
  input wire logic ext1_polarity_bit_in,
  input wire logic ext0_irq_enable_bit_in,
  input wire logic ext1_irq_enable_bit_in,
  input wire logic timer1_irq_enable_bit_in,
  input wire logic [3:0] timer_irq_enable_bits_in,
  input wire logic converter_irq_enable_bit_in,
  input wire logic serial_irq_enable_bit_in,
  input wire logic [fbcis_pkg::NREQ-1:0] request_event_in,
  output logic [fbcis_pkg::NREQ-1:0] request_flags_out,
  input wire logic [fbcis_pkg::ADC_W-1:0] adc_result_in,
  input wire logic converter_mode_bit_in,
  output logic converter_start_out,
  output logic comparator_start_out,
  output logic global_irq_enable_out,
  output logic third_irq_control_out,
  output logic carry_bit_out,
  output logic [7:0] prescaler_reload_out,
  output logic [7:0] timer1_reload_out,
  output logic [7:0] timer2_reload_out,
  output logic [7:0] timer3_reload_out,
  output logic [7:0] timer4_reload_low_out,
  output logic [7:0] timer4_reload_high_out,
  output logic [3:0] lcd_timer_reload_out
);
  function automatic logic is_misc(input logic [9:0] w, input logic [6:0] c);
    return w[9:7] == fbcis_pkg::G_MISC && w[6:0] == c;
  endfunction

  function automatic logic is_imm(input logic [9:0] w, input logic [2:0] s);
    return w[9:7] == fbcis_pkg::G_IMM && w[6:4] == s;
  endfunction

  fbcis_pkg::fbcis_state_t st;
  fbcis_pkg::fbcis_state_t next_st;
  logic [6:0] counter_page_half;
  logic [6:0] counter_inpage_half;
  logic [13:0] return_stack [0:fbcis_pkg::STACK_DEPTH-1];
  logic [2:0] stack_index;
  logic [3:0] acc;
  logic [3:0] breg;
  logic [3:0] idx_x;
  logic [3:0] idx_y;
  logic [1:0] file_z;
  logic carry_bit;
  logic global_irq_enable;
  logic third_irq_control;
  logic skip_pending;
  logic quiet;
  logic [6:0] page_latch;
  logic [7:0] reload_bank [0:fbcis_pkg::NRELOAD-1];
  logic [1:0] pin0_sync;
  logic [1:0] pin1_sync;
  logic [13:0] next_pc;
  logic [3:0] next_acc;
  logic [3:0] next_b;
  logic next_cy;
  logic [8:0] req_hit;
  logic [8:0] req_clear;

  wire [2:0] grp = instr_in[9:7];
  wire [6:0] code = instr_in[6:0];
  wire [3:0] nib = instr_in[3:0];
  wire at_exec = st == fbcis_pkg::ST_EXEC;
  // a pending skip turns every operation decode off for one instruction; a long branch still steps to ST_BL2
  wire live = at_exec && !skip_pending;
  wire any_bl = grp == fbcis_pkg::G_BL;
  wire any_table_read_paged = grp == fbcis_pkg::G_TABLE_READ_PAGED;
  wire any_rt = is_misc(instr_in, fbcis_pkg::M_RT);
  wire any_rts = is_misc(instr_in, fbcis_pkg::M_RTS);
  wire any_rti = is_misc(instr_in, fbcis_pkg::M_RTI);
  wire op_am = live && is_misc(instr_in, fbcis_pkg::M_AM);
  wire op_amc = live && is_misc(instr_in, fbcis_pkg::M_AMC);
  wire op_tam = live && is_misc(instr_in, fbcis_pkg::M_TAM);
  wire op_tma = live && is_misc(instr_in, fbcis_pkg::M_TMA);
  wire op_sc = live && is_misc(instr_in, fbcis_pkg::M_SC);
  wire op_rc = live && is_misc(instr_in, fbcis_pkg::M_RC);
  wire op_di = live && is_misc(instr_in, fbcis_pkg::M_DI);
  wire op_ei = live && is_misc(instr_in, fbcis_pkg::M_EI);
  wire op_read_converter_result = live && is_misc(instr_in, fbcis_pkg::M_READ_CONVERTER_RESULT);
  wire op_read_converter_low_bits = live && is_misc(instr_in, fbcis_pkg::M_READ_CONVERTER_LOW_BITS);
  wire op_converter_start = live && is_misc(instr_in, fbcis_pkg::M_CONVERTER_START);
  wire op_tai3 = live && is_misc(instr_in, fbcis_pkg::M_TAI3);
  wire op_ti3a = live && is_misc(instr_in, fbcis_pkg::M_TI3A);
  wire op_lvl0 = live && is_misc(instr_in, fbcis_pkg::M_LVL0);
  wire op_lvl1 = live && is_misc(instr_in, fbcis_pkg::M_LVL1);
  wire op_rts = live && any_rts;
  wire op_rt = live && (any_rt || any_rts || any_rti);
  wire op_la = live && is_imm(instr_in, fbcis_pkg::I_LA);
  wire op_add = live && is_imm(instr_in, fbcis_pkg::I_ADD);
  wire op_sea = live && is_imm(instr_in, fbcis_pkg::I_SEA);
  wire op_lx = live && is_imm(instr_in, fbcis_pkg::I_LX);
  wire op_ly = live && is_imm(instr_in, fbcis_pkg::I_LY);
  wire op_lz = live && is_imm(instr_in, fbcis_pkg::I_LZ);
  wire op_call = live && grp == fbcis_pkg::G_CALL;
  wire op_br = live && grp == fbcis_pkg::G_BR;
  wire op_reload = live && grp == fbcis_pkg::G_RELOAD;

  wire [13:0] pc = {counter_page_half, counter_inpage_half};
  wire [13:0] pc_inc = pc + 14'h0001;
  wire [2:0] sp_up = stack_index + 3'h1;
  wire [2:0] sp_dn = stack_index - 3'h1;
  wire [13:0] ret_target = return_stack[stack_index];
  wire [9:0] memory_pointer = {file_z, idx_x, idx_y};
  wire [4:0] imm_sum = {1'b0, acc} + {1'b0, nib};
  wire [3:0] am_sum = acc + dmem_rdata_in;
  wire [4:0] amc_sum = {1'b0, acc} + {1'b0, dmem_rdata_in} + {4'h0, carry_bit};
  wire lvl0 = ext0_polarity_bit_in ? pin0_sync[1] : !pin0_sync[1];
  wire lvl1 = ext1_polarity_bit_in ? pin1_sync[1] : !pin1_sync[1];
  wire [8:0] req_enable = {serial_irq_enable_bit_in,
    converter_irq_enable_bit_in, timer_irq_enable_bits_in,
    timer1_irq_enable_bit_in, ext1_irq_enable_bit_in,
    ext0_irq_enable_bit_in};
  wire next_skip = (|req_hit) || (op_lvl0 && lvl0) || (op_lvl1 && lvl1)
    || (op_add && !imm_sum[4]) || (op_sea && acc == nib) || op_rts;

  // a request test with its enable high falls through as a no-operation
  for (genvar k = 0; k < fbcis_pkg::NREQ; k++) begin : g_req
    assign req_hit[k] = live && grp == fbcis_pkg::G_MISC
      && code == fbcis_pkg::M_SKREQ + 7'(k)
      && !req_enable[k] && request_flags_out[k];
    fbcis_flag u_flag (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .set_in(request_event_in[k]),
      .clear_in(req_clear[k]),
      .flag_out(request_flags_out[k])
    );
  end
  assign req_clear = req_hit | ({8'h00, op_converter_start} << fbcis_pkg::R_CONV);

  // skipped long branches still use their second cycle, skipped table reads
  // and plain returns drop their extra cycles
  always_comb begin
    next_st = fbcis_pkg::ST_EXEC;
    unique case (st)
      fbcis_pkg::ST_EXEC: begin
        if (any_bl) begin
          next_st = fbcis_pkg::ST_BL2;
        end else if (!skip_pending && any_table_read_paged) begin
          next_st = fbcis_pkg::ST_TAB2;
        end else if (!skip_pending && (any_rt || any_rts)) begin
          next_st = fbcis_pkg::ST_RET2;
        end
      end
      fbcis_pkg::ST_TAB2: next_st = fbcis_pkg::ST_TAB3;
      fbcis_pkg::ST_BL2, fbcis_pkg::ST_TAB3, fbcis_pkg::ST_RET2:
        next_st = fbcis_pkg::ST_EXEC;
    endcase
  end

  always_comb begin
    next_pc = pc_inc;
    if (st == fbcis_pkg::ST_TAB2 || st == fbcis_pkg::ST_TAB3
        || st == fbcis_pkg::ST_RET2) begin
      next_pc = pc;
    end
    if (op_br) begin
      next_pc = {counter_page_half, code};
    end
    if (op_call) begin
      next_pc = {fbcis_pkg::CALL_PAGE, code};
    end
    if (op_rt) begin
      next_pc = ret_target;
    end
    if (st == fbcis_pkg::ST_BL2 && !quiet) begin
      next_pc = {page_latch, code};
    end
  end

  always_comb begin
    next_acc = acc;
    next_b = breg;
    next_cy = carry_bit;
    if (op_la) next_acc = nib;
    if (op_add) next_acc = imm_sum[3:0];
    if (op_am) next_acc = am_sum;
    if (op_amc) {next_cy, next_acc} = amc_sum;
    if (op_tam) next_acc = dmem_rdata_in;
    if (op_sc) next_cy = 1'b1;
    if (op_rc) next_cy = 1'b0;
    if (op_read_converter_result) begin
      next_b = converter_mode_bit_in ? adc_result_in[7:4]
        : adc_result_in[9:6];
      next_acc = converter_mode_bit_in ? adc_result_in[3:0]
        : adc_result_in[5:2];
    end
    if (op_read_converter_low_bits) next_acc = {adc_result_in[1:0], 2'b00};
    if (op_tai3) next_acc = {3'b000, third_irq_control};
    if (st == fbcis_pkg::ST_TAB2) {next_b, next_acc} = instr_in[7:0];
  end

  // the table row comes from the page operand and the accumulator
  assign pmem_addr_out = (st == fbcis_pkg::ST_TAB2)
    ? {page_latch, 3'h0, acc} : pc;
  assign dmem_addr_out = memory_pointer;
  assign dmem_wdata_out = acc;
  assign dmem_we_out = op_tma;
  assign global_irq_enable_out = global_irq_enable;
  assign third_irq_control_out = third_irq_control;
  assign carry_bit_out = carry_bit;
  assign prescaler_reload_out = reload_bank[fbcis_pkg::RL_PS];
  assign timer1_reload_out = reload_bank[fbcis_pkg::RL_T1];
  assign timer2_reload_out = reload_bank[fbcis_pkg::RL_T2];
  assign timer3_reload_out = reload_bank[fbcis_pkg::RL_T3];
  assign timer4_reload_low_out = reload_bank[fbcis_pkg::RL_T4L];
  assign timer4_reload_high_out = reload_bank[fbcis_pkg::RL_T4H];
  assign lcd_timer_reload_out = reload_bank[fbcis_pkg::RL_LCD][3:0];

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st <= fbcis_pkg::ST_EXEC;
      counter_page_half <= fbcis_pkg::PC_RESET[13:7];
      counter_inpage_half <= fbcis_pkg::PC_RESET[6:0];
      skip_pending <= fbcis_pkg::BIT_RESET;
      quiet <= fbcis_pkg::BIT_RESET;
      page_latch <= fbcis_pkg::PC_RESET[13:7];
    end else begin
      st <= next_st;
      counter_page_half <= next_pc[13:7];
      counter_inpage_half <= next_pc[6:0];
      if (at_exec) begin
        skip_pending <= next_skip;
        quiet <= skip_pending;
        page_latch <= code;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stack_index <= fbcis_pkg::SP_RESET;
    end else if (op_call) begin
      stack_index <= sp_up;
    end else if (op_rt) begin
      stack_index <= sp_dn;
    end
  end

  // stack cells carry no reset; software never reads an unpushed level
  always_ff @(posedge clk_in) begin
    if (op_call) begin
      return_stack[sp_up] <= pc_inc;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acc <= fbcis_pkg::NIB_RESET;
      breg <= fbcis_pkg::NIB_RESET;
      carry_bit <= fbcis_pkg::BIT_RESET;
    end else begin
      acc <= next_acc;
      breg <= next_b;
      carry_bit <= next_cy;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_x <= fbcis_pkg::NIB_RESET;
      idx_y <= fbcis_pkg::NIB_RESET;
      file_z <= fbcis_pkg::NIB_RESET[1:0];
    end else begin
      if (op_lx) idx_x <= nib;
      if (op_ly) idx_y <= nib;
      if (op_lz) file_z <= nib[1:0];
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      global_irq_enable <= fbcis_pkg::BIT_RESET;
      third_irq_control <= fbcis_pkg::BIT_RESET;
      converter_start_out <= fbcis_pkg::BIT_RESET;
      comparator_start_out <= fbcis_pkg::BIT_RESET;
    end else begin
      if (op_di) global_irq_enable <= 1'b0;
      if (op_ei) global_irq_enable <= 1'b1;
      if (op_ti3a) third_irq_control <= acc[0];
      converter_start_out <= op_converter_start && !converter_mode_bit_in;
      comparator_start_out <= op_converter_start && converter_mode_bit_in;
    end
  end

  // code 7 of the reload group selects nothing and is dropped
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int i = 0; i < fbcis_pkg::NRELOAD; i++) begin
        reload_bank[i] <= fbcis_pkg::RELOAD_RESET;
      end
    end else if (op_reload && code[2:0] < 3'(fbcis_pkg::NRELOAD)) begin
      reload_bank[code[2:0]] <= {breg, acc};
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin0_sync <= 2'b00;
      pin1_sync <= 2'b00;
    end else begin
      pin0_sync <= {pin0_sync[0], ext0_pin_in};
      pin1_sync <= {pin1_sync[0], ext1_pin_in};
    end
  end

  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  sequence s_bl_skipped;
    at_exec && skip_pending && any_bl;
  endsequence

  sequence s_plain_return;
    op_rt && (any_rt || any_rts);
  endsequence

  a_skip_noeffect:
    assert property (at_exec && skip_pending
      && is_misc(instr_in, fbcis_pkg::M_AMC)
      |=> $stable(acc) && $stable(carry_bit))
    else $error("suppressed add changed accumulator or carry");
  a_skip_pc_step:
    assert property (at_exec && skip_pending |=> pc == $past(pc_inc))
    else $error("suppressed instruction moved counter by more than one");
  a_skip_bl_cycles:
    assert property (s_bl_skipped |=> st == fbcis_pkg::ST_BL2
      ##1 at_exec && pc == $past(pc_inc, 2) + 14'h0001)
    else $error("suppressed long branch did not take two cycles");
  a_skip_short:
    assert property (at_exec && skip_pending
      && (any_table_read_paged || any_rt || any_rts) |=> at_exec)
    else $error("suppressed table read or return took extra cycles");
  a_call_push:
    assert property (op_call |=> stack_index == $past(sp_up)
      && ret_target == $past(pc_inc)
      && counter_page_half == fbcis_pkg::CALL_PAGE)
    else $error("call did not push next address");
  a_return_pop:
    assert property (s_plain_return |=> pc == $past(ret_target)
      && stack_index == $past(sp_dn) ##1 at_exec && skip_pending
      == $past(any_rts, 2))
    else $error("return did not restore counter and index");
  a_amc_sum:
    assert property (op_amc |=> {carry_bit, acc} == $past(amc_sum))
    else $error("add with carry gave a wrong sum");
  a_add_keep_cy:
    assert property (op_add || op_am |=> carry_bit == $past(carry_bit))
    else $error("add without carry changed the carry flag");
  a_req_gate:
    assert property (live && is_misc(instr_in, fbcis_pkg::M_SKREQ)
      |=> skip_pending == $past(!ext0_irq_enable_bit_in
      && request_flags_out[fbcis_pkg::R_EXT0]))
    else $error("external request test skipped against its enable");
  a_level_skip:
    assert property (op_lvl1 |=> skip_pending == $past(lvl1))
    else $error("pin level test skipped on wrong level");
  a_result_read:
    assert property (op_read_converter_result && !converter_mode_bit_in
      |=> {breg, acc} == $past(adc_result_in[9:2]))
    else $error("converter result read placed wrong bits");
  a_conv_start:
    assert property (op_converter_start |=> converter_start_out
      == !$past(converter_mode_bit_in)
      && comparator_start_out == $past(converter_mode_bit_in))
    else $error("converter start did not follow mode bit");
endmodule

/* File: sim/fbcis_mem_model.sv */
`timescale 1ns/1ps
// program and data memory model standing beside the core
module fbcis_mem_model (
  input wire logic clk_in,
  input wire logic [fbcis_pkg::PC_W-1:0] pmem_addr_in,
  output logic [fbcis_pkg::WORD_W-1:0] instr_out,
  input wire logic [fbcis_pkg::DP_W-1:0] dmem_addr_in,
  output logic [fbcis_pkg::NIB_W-1:0] dmem_rdata_out,
  input wire logic [fbcis_pkg::NIB_W-1:0] dmem_wdata_in,
  input wire logic dmem_we_in
);
  logic [fbcis_pkg::WORD_W-1:0] rom [0:(1<<fbcis_pkg::PC_W)-1];
  // unwritten cells stay unknown, so a stray read shows up at once
  logic [fbcis_pkg::NIB_W-1:0] ram [0:(1<<fbcis_pkg::DP_W)-1];
  // same-cycle reads, no wait states
  assign instr_out = rom[pmem_addr_in];
  assign dmem_rdata_out = ram[dmem_addr_in];
  // plain always: the bench preloads cells of this array by reference
  always @(posedge clk_in) begin
    if (dmem_we_in) begin
      ram[dmem_addr_in] <= dmem_wdata_in;
    end
  end
endmodule

/* File: sim/fbcis_bench.sv */
`timescale 1ns/1ps
// self-checking bench running a short program through the core
module fbcis_bench;
  logic clk_in = 1'b0;
  logic rst_in;
  logic [13:0] pa;
  logic [9:0] instr, da;
  logic [3:0] rd, wd, t4en, lcd;
  logic we, p0, p1, pol0, pol1, en0, en1, ent1, encv, ensr, mode;
  logic cst, mst, gie, i3, cy;
  logic [8:0] ev, flags;
  logic [9:0] adc;
  logic [7:0] r_ps, r_t1, r_t2, r_t3, r_t4l, r_t4h;
  int n_fail = 0;
  int comparisons = 0;
  int cyc;
  always #2 clk_in = ~clk_in;
  fbcis_core i_fbcis_core (.clk_in(clk_in), .rst_in(rst_in),
    .pmem_addr_out(pa), .instr_in(instr), .dmem_addr_out(da),
    .dmem_rdata_in(rd), .dmem_wdata_out(wd), .dmem_we_out(we),
    .ext0_pin_in(p0), .ext1_pin_in(p1), .ext0_polarity_bit_in(pol0),
    .ext1_polarity_bit_in(pol1), .ext0_irq_enable_bit_in(en0),
    .ext1_irq_enable_bit_in(en1), .timer1_irq_enable_bit_in(ent1),
    .timer_irq_enable_bits_in(t4en), .converter_irq_enable_bit_in(encv),
    .serial_irq_enable_bit_in(ensr), .request_event_in(ev),
    .request_flags_out(flags), .adc_result_in(adc),
    .converter_mode_bit_in(mode), .converter_start_out(cst),
    .comparator_start_out(mst), .global_irq_enable_out(gie),
    .third_irq_control_out(i3), .carry_bit_out(cy),
    .prescaler_reload_out(r_ps), .timer1_reload_out(r_t1),
    .timer2_reload_out(r_t2), .timer3_reload_out(r_t3),
    .timer4_reload_low_out(r_t4l), .timer4_reload_high_out(r_t4h),
    .lcd_timer_reload_out(lcd));
  fbcis_mem_model i_fbcis_mem_model (.clk_in(clk_in), .pmem_addr_in(pa),
    .instr_out(instr), .dmem_addr_in(da), .dmem_rdata_out(rd),
    .dmem_wdata_in(wd), .dmem_we_in(we));
  function automatic logic [9:0] mi(input logic [6:0] code);
    return {fbcis_pkg::G_MISC, code};
  endfunction
  function automatic logic [9:0] im(input logic [2:0] sub, logic [3:0] n);
    return {fbcis_pkg::G_IMM, sub, n};
  endfunction
  task automatic put(input int a, input logic [9:0] w);
    i_fbcis_mem_model.rom[a] = w;
  endtask
  task automatic chk(input string name, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // waits at falling edges until the given word is being fetched
  task automatic run_to(input logic [13:0] addr, output int n);
    n = 0;
    while (pa !== addr && n < 200) begin
      @(negedge clk_in);
      n++;
    end
    chk("fetch address", {2'h0, pa}, {2'h0, addr});
  endtask
  task automatic end_sim();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    #4000;
    n_fail++;
    end_sim();
  end
  initial begin
    rst_in = 1'b1;
    {p0, p1, pol0, pol1, en1} = 5'b10111;
    {en0, ent1, encv, ensr, mode} = 5'b00000;
    t4en = 4'h0;
    ev = 9'h000;
    adc = 10'h2D6;
    for (int i = 0; i < (1 << fbcis_pkg::PC_W); i++) put(i, 10'h000);
    i_fbcis_mem_model.ram[10'h123] = 4'h9;
    put(0, im(fbcis_pkg::I_LZ, 4'h1));
    put(1, im(fbcis_pkg::I_LX, 4'h2));
    put(2, im(fbcis_pkg::I_LY, 4'h3));
    put(3, mi(fbcis_pkg::M_SC));
    put(4, im(fbcis_pkg::I_LA, 4'h7));
    put(5, mi(fbcis_pkg::M_AMC));
    put(6, mi(fbcis_pkg::M_TMA));
    put(7, im(fbcis_pkg::I_ADD, 4'hF));
    put(8, mi(fbcis_pkg::M_SKREQ + 7'(fbcis_pkg::R_EXT1)));
    put(9, mi(fbcis_pkg::M_SKREQ + 7'(fbcis_pkg::R_T1)));
    put(10, im(fbcis_pkg::I_LA, 4'h5));
    put(11, mi(fbcis_pkg::M_TMA));
    put(12, mi(fbcis_pkg::M_EI));
    put(13, mi(fbcis_pkg::M_READ_CONVERTER_RESULT));
    put(14, {fbcis_pkg::G_RELOAD, 7'(fbcis_pkg::RL_T4H)});
    put(15, mi(fbcis_pkg::M_READ_CONVERTER_LOW_BITS));
    put(16, mi(fbcis_pkg::M_TMA));
    put(17, mi(fbcis_pkg::M_CONVERTER_START));
    put(18, {fbcis_pkg::G_CALL, 7'h0A});
    put(14'h010A, mi(fbcis_pkg::M_RT));
    put(19, mi(fbcis_pkg::M_SKREQ + 7'(fbcis_pkg::R_EXT0)));
    put(20, mi(fbcis_pkg::M_RT));
    put(21, mi(fbcis_pkg::M_LVL0));
    put(22, mi(fbcis_pkg::M_DI));
    put(23, mi(fbcis_pkg::M_LVL1));
    put(24, im(fbcis_pkg::I_LA, 4'h3));
    put(25, mi(fbcis_pkg::M_TI3A));
    put(26, im(fbcis_pkg::I_LA, 4'h0));
    put(27, mi(fbcis_pkg::M_TAI3));
    put(28, mi(fbcis_pkg::M_TMA));
    put(30, mi(fbcis_pkg::M_SKREQ + 7'(fbcis_pkg::R_CONV)));
    put(31, im(fbcis_pkg::I_LA, 4'h4));
    put(32, mi(fbcis_pkg::M_SKREQ + 7'(fbcis_pkg::R_SER)));
    put(33, mi(fbcis_pkg::M_AMC));
    put(34, mi(fbcis_pkg::M_TMA));
    put(35, mi(fbcis_pkg::M_READ_CONVERTER_RESULT));
    put(36, {fbcis_pkg::G_RELOAD, 7'(fbcis_pkg::RL_T2)});
    put(37, {fbcis_pkg::G_RELOAD, 7'(fbcis_pkg::RL_LCD)});
    put(38, mi(fbcis_pkg::M_CONVERTER_START));
    put(39, {fbcis_pkg::G_BL, 7'h03});
    put(40, 10'h010);
    put(14'h0190, {fbcis_pkg::G_TABLE_READ_PAGED, 7'h04});
    put(14'h0206, 10'h05A);
    put(14'h0191, {fbcis_pkg::G_RELOAD, 7'(fbcis_pkg::RL_T1)});
    put(14'h0192, im(fbcis_pkg::I_SEA, 4'hA));
    put(14'h0193, {fbcis_pkg::G_TABLE_READ_PAGED, 7'h04});
    put(14'h0194, im(fbcis_pkg::I_SEA, 4'hA));
    put(14'h0195, {fbcis_pkg::G_BL, 7'h00});
    put(14'h0197, mi(fbcis_pkg::M_DI));
    put(14'h0198, {fbcis_pkg::G_BR, 7'h18});
    repeat (2) @(negedge clk_in);
    rst_in = 1'b0;
    @(negedge clk_in);
    ev = 9'h007;
    @(negedge clk_in);
    ev = 9'h000;
    run_to(14'd3, cyc);
    chk("pointer", {6'h0, da}, 16'h0123);
    run_to(14'd7, cyc);
    chk("sum", {12'h0, i_fbcis_mem_model.ram[10'h123]}, 16'h1);
    chk("carry", {15'h0, cy}, 16'h1);
    run_to(14'd8, cyc);
    chk("carry kept", {15'h0, cy}, 16'h1);
    run_to(14'd12, cyc);
    chk("skip load", {12'h0, i_fbcis_mem_model.ram[10'h123]}, 16'h0);
    chk("timer flag", {15'h0, flags[fbcis_pkg::R_T1]}, 16'h0);
    chk("ext1 flag", {15'h0, flags[fbcis_pkg::R_EXT1]}, 16'h1);
    run_to(14'd13, cyc);
    chk("enable set", {15'h0, gie}, 16'h1);
    run_to(14'd15, cyc);
    chk("result high", {8'h0, r_t4h}, 16'h00B5);
    run_to(14'd17, cyc);
    chk("low bits", {12'h0, i_fbcis_mem_model.ram[10'h123]}, 16'h8);
    run_to(14'd18, cyc);
    chk("start pulse", {14'h0, cst, mst}, 16'h2);
    run_to(14'd20, cyc);
    chk("call and return", 16'(cyc), 16'd4);
    run_to(14'd21, cyc);
    chk("skipped return", 16'(cyc), 16'd1);
    chk("ext0 flag", {15'h0, flags[fbcis_pkg::R_EXT0]}, 16'h0);
    run_to(14'd23, cyc);
    chk("level skip", {15'h0, gie}, 16'h1);
    run_to(14'd29, cyc);
    chk("third control", {15'h0, i3}, 16'h1);
    chk("ctl read", {12'h0, i_fbcis_mem_model.ram[10'h123]}, 16'h1);
    ev = 9'h180;
    @(negedge clk_in);
    ev = 9'h000;
    mode = 1'b1;
    run_to(14'd35, cyc);
    chk("done flags", {14'h0, flags[8], flags[7]}, 16'h0);
    chk("skips", {12'h0, i_fbcis_mem_model.ram[10'h123]}, 16'h1);
    run_to(14'd39, cyc);
    chk("compare read", {8'h0, r_t2}, 16'h00D6);
    chk("lcd reload", {12'h0, lcd}, 16'h6);
    chk("compare start", {14'h0, cst, mst}, 16'h1);
    run_to(14'h0192, cyc);
    chk("long branch", 16'(cyc), 16'd6);
    chk("table read", {8'h0, r_t1}, 16'h005A);
    run_to(14'h0198, cyc);
    chk("skipped steps", 16'(cyc), 16'd6);
    chk("disable", {15'h0, gie}, 16'h0);
    end_sim();
  end
endmodule
